// *** t16c_pkg.sv ***
// Package of constants for the 16-bit timer counter with input capture
package t16c_pkg;
    // CPU byte addresses of the registers
    localparam logic [3:0] ADDR_CNT_LO   = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI   = 4'h1;
    localparam logic [3:0] ADDR_CAP_LO   = 4'h2;
    localparam logic [3:0] ADDR_CAP_HI   = 4'h3;
    localparam logic [3:0] ADDR_CTRL_A   = 4'h4;
    localparam logic [3:0] ADDR_CTRL_B   = 4'h5;
    localparam logic [3:0] ADDR_FLAGS    = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h7;
    localparam logic [3:0] ADDR_CMP_CTRL = 4'h8;
    // Control register A fields
    localparam int WGM_A_LSB = 0;
    // Control register B fields
    localparam int CS_LSB    = 0;
    localparam int WGM_B_LSB = 3;
    localparam int NF_BIT    = 7;
    // Flag and enable positions, control B edge select bit and comparator capture select bit
    localparam int OVF_BIT   = 0;
    localparam int CAPF_BIT  = 1;
    localparam int EDGE_BIT  = 6;
    localparam int COMPARATOR_CAPTURE_SELECT_BIT  = 2;
    // Clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    // Waveform modes; all but WGM_NORMAL take TOP from the capture register
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hc;
    localparam logic [3:0] WGM_PWM_CAP  = 4'he;
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'ha;
    // Fixed values
    localparam logic [15:0] BOTTOM_VAL = 16'h0000;
    localparam logic [15:0] MAX_VAL    = 16'hffff;
    localparam logic [15:0] RESET_16   = 16'h0000;
    localparam logic [7:0]  RESET_8    = 8'h00;
    // Noise filter sample count
    localparam int NF_SAMPLES = 4;
endpackage

// *** t16c_noise_filter.sv ***
// Four-sample noise filter for the capture input
`timescale 1ns/1ps
module t16c_noise_filter (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic [t16c_pkg::NF_SAMPLES-2:0] hist_reg;
    logic [t16c_pkg::NF_SAMPLES-1:0] window;

    // Current input is the fourth sample, so filtering costs exactly four cycles
    assign window = {hist_reg, din};

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= {hist_reg[t16c_pkg::NF_SAMPLES-3:0], din};
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dout <= 1'b0;
        end else if (&window) begin
            dout <= 1'b1;
        end else if (~|window) begin
            dout <= 1'b0;
        end
    end
endmodule

// *** t16c_timer.sv ***
// 16-bit timer counter with input capture and byte-wise CPU access
`timescale 1ns/1ps
// Contract
// - Counter shows as two bytes; high location reaches shared holding register.
// - Each timer tick clears, increments or decrements the counter per mode.
// - Clock select picks tick source; zero stops the counter.
// - CPU may read and write the counter whether running or not.
// - A CPU counter write beats a same-cycle clear or count.
// - Four-bit waveform mode, split over control A and B, sets sequence.
// - Overflow flag set where the mode defines; may request interrupt.
// - Matching edge on selected capture input copies counter into capture.
// - Capture flag sets with the copy; enable bit raises request.
// - Capture flag clears on service or on software writing one.
// - Capture read low first; low read loads holding with high byte.
// - Capture register writable only in modes using it as TOP.
// - Comparator select bit switches trigger to comparator output.
// - Switching trigger source may capture; software clears flag afterwards.
// - Filter and edge path disabled in modes using capture as TOP.
// - Filter output changes only after four equal samples.
// - Filter enable adds four system clocks of capture delay.
// - Filter runs on system clock, independent of prescaler.
// - Capture pin observed even when software drives it.
// - BOTTOM is zero; low write moves holding plus low in one cycle.
// - Low-byte write loads whole 16-bit register atomically.
module t16c_timer (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [3:0] cpu_addr,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    input  wire logic       ext_tick,
    input  wire logic       capture_pin,
    input  wire logic       comparator_output,
    input  wire logic       ovf_irq_ack,
    input  wire logic       cap_irq_ack,
    output logic            ovf_irq,
    output logic            cap_irq,
    output logic            top_pulse,
    output logic            bottom_pulse,
    output logic            count_down,
    output logic      [3:0] waveform_mode_field
);
    logic [15:0] count_value_reg;
    logic [15:0] capture_value_reg;
    logic [7:0]  hold_reg;
    logic [7:0]  control_reg_a;
    logic [7:0]  control_reg_b;
    logic [7:0]  irq_en_reg;
    logic [7:0]  comparator_control_reg;
    logic        overflow_flag;
    logic        capture_flag;
    logic [5:0]  presc_reg;
    logic        dir_down_reg;
    logic        cap_raw_reg;
    logic        cap_prev_reg;
    logic        src_prev_reg;
    logic        filt_out;
    logic        timer_tick;
    logic [3:0]  wgm;
    logic [2:0]  clock_source_select;
    logic        cap_is_top;
    logic [15:0] top_val;
    logic        wr_cnt_lo;
    logic        wr_cap_lo;
    logic        rd_cnt_lo;
    logic        rd_cap_lo;
    logic        cap_sel;
    logic        edge_in;
    logic        cap_trig;
    logic        at_top;
    logic        at_bottom;
    logic        dual_slope;
    logic        set_ovf;

    // mode bits from both control registers
    assign wgm = {control_reg_b[t16c_pkg::WGM_B_LSB+1:t16c_pkg::WGM_B_LSB],
                  control_reg_a[t16c_pkg::WGM_A_LSB+1:t16c_pkg::WGM_A_LSB]};
    assign clock_source_select = control_reg_b[t16c_pkg::CS_LSB+2:t16c_pkg::CS_LSB];
    assign cap_is_top = (wgm == t16c_pkg::WGM_CTC_CAP) || (wgm == t16c_pkg::WGM_PWM_CAP)
                     || (wgm == t16c_pkg::WGM_PFC_CAP) || (wgm == t16c_pkg::WGM_PC_CAP);
    assign dual_slope = (wgm == t16c_pkg::WGM_PFC_CAP) || (wgm == t16c_pkg::WGM_PC_CAP);
    assign top_val = cap_is_top ? capture_value_reg : t16c_pkg::MAX_VAL;

    assign wr_cnt_lo = cpu_wr && (cpu_addr == t16c_pkg::ADDR_CNT_LO);
    assign wr_cap_lo = cpu_wr && (cpu_addr == t16c_pkg::ADDR_CAP_LO);
    assign rd_cnt_lo = cpu_rd && (cpu_addr == t16c_pkg::ADDR_CNT_LO);
    assign rd_cap_lo = cpu_rd && (cpu_addr == t16c_pkg::ADDR_CAP_LO);

    // Prescaler divider on the system clock
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 6'h01;
        end
    end

    always_comb begin
        case (clock_source_select)
            t16c_pkg::CS_STOP:  timer_tick = 1'b0;
            t16c_pkg::CS_DIV1:  timer_tick = 1'b1;
            t16c_pkg::CS_DIV8:  timer_tick = (presc_reg[2:0] == 3'h7);
            t16c_pkg::CS_DIV64: timer_tick = (presc_reg == 6'h3f);
            default:            timer_tick = ext_tick;
        endcase
    end

    assign at_bottom = (count_value_reg == t16c_pkg::BOTTOM_VAL);
    assign at_top    = (count_value_reg == top_val);

    // Direction for dual-slope modes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dir_down_reg <= 1'b0;
        end else if (!dual_slope) begin
            dir_down_reg <= 1'b0;
        end else if (timer_tick && !wr_cnt_lo) begin
            if (at_top) begin
                dir_down_reg <= 1'b1;
            end else if (at_bottom) begin
                dir_down_reg <= 1'b0;
            end
        end
    end

    // low-location write moves holding into high byte
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count_value_reg <= t16c_pkg::RESET_16;
        end else if (wr_cnt_lo) begin
            count_value_reg <= {hold_reg, cpu_wdata};
        end else if (timer_tick) begin
            // clear, up or down per mode
            if (dual_slope) begin
                if ((dir_down_reg && !at_bottom) || at_top) begin
                    count_value_reg <= count_value_reg - 16'h0001;
                end else begin
                    count_value_reg <= count_value_reg + 16'h0001;
                end
            end else if (at_top) begin
                count_value_reg <= t16c_pkg::RESET_16;
            end else begin
                count_value_reg <= count_value_reg + 16'h0001;
            end
        end
    end

    // overflow point per mode: bottom in dual slope, else top/max
    assign set_ovf = timer_tick && !wr_cnt_lo
                  && (dual_slope ? (at_bottom && dir_down_reg) : at_top);

    // holding register: high writes, low reads load it
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hold_reg <= t16c_pkg::RESET_8;
        end else if (cpu_wr && ((cpu_addr == t16c_pkg::ADDR_CNT_HI)
                                || (cpu_addr == t16c_pkg::ADDR_CAP_HI))) begin
            hold_reg <= cpu_wdata;
        end else if (rd_cnt_lo) begin
            hold_reg <= count_value_reg[15:8];
        end else if (rd_cap_lo) begin
            hold_reg <= capture_value_reg[15:8];
        end
    end

    // Control registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            control_reg_a          <= t16c_pkg::RESET_8;
            control_reg_b          <= t16c_pkg::RESET_8;
            irq_en_reg             <= t16c_pkg::RESET_8;
            comparator_control_reg <= t16c_pkg::RESET_8;
        end else if (cpu_wr) begin
            case (cpu_addr)
                t16c_pkg::ADDR_CTRL_A:   control_reg_a <= cpu_wdata;
                t16c_pkg::ADDR_CTRL_B:   control_reg_b <= cpu_wdata;
                t16c_pkg::ADDR_IRQ_EN:   irq_en_reg <= cpu_wdata;
                t16c_pkg::ADDR_CMP_CTRL: comparator_control_reg <= cpu_wdata;
                default: ;
            endcase
        end
    end

    // pin level sampled regardless of who drives it
    assign cap_sel = comparator_control_reg[t16c_pkg::COMPARATOR_CAPTURE_SELECT_BIT]
                   ? comparator_output : capture_pin;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cap_raw_reg <= 1'b0;
        end else begin
            cap_raw_reg <= cap_sel;
        end
    end

    t16c_noise_filter u_filter (
        .mclk (mclk),
        .nrst (nrst),
        .din  (cap_raw_reg),
        .dout (filt_out)
    );

    assign edge_in = control_reg_b[t16c_pkg::NF_BIT] ? filt_out : cap_raw_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cap_prev_reg <= 1'b0;
            src_prev_reg <= 1'b0;
        end else begin
            cap_prev_reg <= edge_in;
            src_prev_reg <= cap_prev_reg;
        end
    end

    // edge path off when capture is TOP
    // a source switch looks like an edge and may capture
    assign cap_trig = !cap_is_top && (cap_prev_reg != src_prev_reg)
                   && (cap_prev_reg == control_reg_b[t16c_pkg::EDGE_BIT]);

    // copy counter on trigger; writes only when TOP
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            capture_value_reg <= t16c_pkg::RESET_16;
        end else if (wr_cap_lo && cap_is_top) begin
            capture_value_reg <= {hold_reg, cpu_wdata};
        end else if (cap_trig) begin
            capture_value_reg <= count_value_reg;
        end
    end

    // flag with copy; clear by ack or one written, set wins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            capture_flag <= 1'b0;
        end else if (cap_trig) begin
            capture_flag <= 1'b1;
        end else if (cap_irq_ack || (cpu_wr && (cpu_addr == t16c_pkg::ADDR_FLAGS)
                                     && cpu_wdata[t16c_pkg::CAPF_BIT])) begin
            capture_flag <= 1'b0;
        end
    end

    // overflow flag, set wins over clear
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            overflow_flag <= 1'b0;
        end else if (set_ovf) begin
            overflow_flag <= 1'b1;
        end else if (ovf_irq_ack || (cpu_wr && (cpu_addr == t16c_pkg::ADDR_FLAGS)
                                     && cpu_wdata[t16c_pkg::OVF_BIT])) begin
            overflow_flag <= 1'b0;
        end
    end

    // Registered outputs to compare unit and interrupt controller
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ovf_irq             <= 1'b0;
            cap_irq             <= 1'b0;
            top_pulse           <= 1'b0;
            bottom_pulse        <= 1'b0;
            count_down          <= 1'b0;
            waveform_mode_field <= t16c_pkg::WGM_NORMAL;
        end else begin
            ovf_irq             <= (overflow_flag || set_ovf) && irq_en_reg[t16c_pkg::OVF_BIT];
            cap_irq             <= (capture_flag || cap_trig) && irq_en_reg[t16c_pkg::CAPF_BIT];
            top_pulse           <= timer_tick && at_top;
            bottom_pulse        <= timer_tick && at_bottom;
            count_down          <= dir_down_reg;
            waveform_mode_field <= wgm;
        end
    end

    // high location reads the holding register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cpu_rdata <= t16c_pkg::RESET_8;
        end else if (cpu_rd) begin
            case (cpu_addr)
                t16c_pkg::ADDR_CNT_LO:   cpu_rdata <= count_value_reg[7:0];
                t16c_pkg::ADDR_CNT_HI:   cpu_rdata <= hold_reg;
                t16c_pkg::ADDR_CAP_LO:   cpu_rdata <= capture_value_reg[7:0];
                t16c_pkg::ADDR_CAP_HI:   cpu_rdata <= hold_reg;
                t16c_pkg::ADDR_CTRL_A:   cpu_rdata <= control_reg_a;
                t16c_pkg::ADDR_CTRL_B:   cpu_rdata <= control_reg_b;
                t16c_pkg::ADDR_FLAGS:    cpu_rdata <= {6'h00, capture_flag, overflow_flag};
                t16c_pkg::ADDR_IRQ_EN:   cpu_rdata <= irq_en_reg;
                t16c_pkg::ADDR_CMP_CTRL: cpu_rdata <= comparator_control_reg;
                default:                 cpu_rdata <= t16c_pkg::RESET_8;
            endcase
        end
    end
endmodule

// *** t16c_checker.sv ***
// Port-level assertions for the 16-bit timer with input capture
`timescale 1ns/1ps
module t16c_checker (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic [3:0] cpu_addr,
    input wire logic       cpu_wr,
    input wire logic       cpu_rd,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic       cap_irq_ack,
    input wire logic       ovf_irq,
    input wire logic       cap_irq,
    input wire logic       top_pulse,
    input wire logic       bottom_pulse,
    input wire logic       count_down,
    input wire logic [3:0] waveform_mode_field
);
    logic [2:0] cs_q;
    logic       cen_q;
    logic       dual_q;
    logic       wr_b;
    logic       cap_clr;
    assign wr_b = cpu_wr && cpu_addr == t16c_pkg::ADDR_CTRL_B;
    // Any access that may lower the capture request two cycles later
    assign cap_clr = cap_irq_ack || cpu_wr && (cpu_addr == t16c_pkg::ADDR_IRQ_EN
                     || cpu_addr == t16c_pkg::ADDR_FLAGS && cpu_wdata[1]);
    // Shadow of clock select and capture enable as written by the CPU
    always_ff @(posedge mclk) begin
        if (!nrst) cs_q <= 3'h0;
        else if (wr_b) cs_q <= cpu_wdata[2:0];
    end
    always_ff @(posedge mclk) begin
        if (!nrst) cen_q <= 1'b0;
        else if (cpu_wr && cpu_addr == t16c_pkg::ADDR_IRQ_EN) cen_q <= cpu_wdata[1];
    end
    always_ff @(posedge mclk) begin
        if (!nrst) dual_q <= 1'b0;
        else if (waveform_mode_field[3:2] == 2'h2) dual_q <= 1'b1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_reset_quiet: assert property (
        $rose(nrst) |-> cpu_rdata == 8'h00 && !ovf_irq && !cap_irq)
        else $error("outputs not cleared by reset");
    chk_mode_high: assert property (
        wr_b |-> ##2 waveform_mode_field[3:2] == $past(cpu_wdata[4:3], 2))
        else $error("mode high bits not taken from control B");
    chk_mode_low: assert property (
        cpu_wr && cpu_addr == t16c_pkg::ADDR_CTRL_A
        |-> ##2 waveform_mode_field[1:0] == $past(cpu_wdata[1:0], 2))
        else $error("mode low bits not taken from control A");
    chk_stop_quiet: assert property (
        cs_q == 3'h0 && $past(cs_q) == 3'h0 |-> !top_pulse && !bottom_pulse)
        else $error("counter event while stopped");
    chk_single_up: assert property (
        !dual_q |-> !count_down)
        else $error("down count outside dual slope modes");
    chk_cap_flag_hold: assert property (
        cap_irq && !$past(cap_clr) |=> cap_irq)
        else $error("capture request dropped without clear");
    chk_cap_enable: assert property (
        !cen_q && !$past(cen_q) |-> !cap_irq)
        else $error("capture request while disabled");
    chk_rdata_hold: assert property (
        !$past(cpu_rd) |-> $stable(cpu_rdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (
        cpu_rd && cpu_addr > t16c_pkg::ADDR_CMP_CTRL |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// *** t16c_cpu_model.sv ***
// CPU side model: byte bus master for the timer registers
`timescale 1ns/1ps
module t16c_cpu_model (
    input  wire logic       mclk,
    output logic      [3:0] cpu_addr,
    output logic            cpu_wr,
    output logic            cpu_rd,
    output logic      [7:0] cpu_wdata,
    input  wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_addr = 4'h0;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
        cpu_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        #1;
        d = cpu_rdata;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 4'h1, v[15:8]);
    endtask
    task automatic clr_cap;
        wr(t16c_pkg::ADDR_FLAGS, 8'h02);
    endtask
endmodule

// *** t16c_timer_tb.sv ***
// Self-checking bench for the 16-bit timer with input capture
`timescale 1ns/1ps
module t16c_timer_tb;
    logic        mclk;
    logic        nrst;
    logic [3:0]  cpu_addr;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        capture_pin;
    logic        comparator_output;
    logic        ovf_irq_ack;
    logic        cap_irq_ack;
    logic        ovf_irq;
    logic        cap_irq;
    logic        top_pulse;
    logic        bottom_pulse;
    logic        count_down;
    logic [3:0]  waveform_mode_field;
    logic        saw_bot;
    logic        saw_top;
    logic        ext_tick;
    logic [15:0] v;
    logic [7:0]  b;
    int          miscompares;
    int          n_tests;
    int          cyc;
    int          l0;
    int          l1;
    t16c_timer DUT (.mclk(mclk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .ext_tick(ext_tick),
        .capture_pin(capture_pin), .comparator_output(comparator_output),
        .ovf_irq_ack(ovf_irq_ack), .cap_irq_ack(cap_irq_ack), .ovf_irq(ovf_irq),
        .cap_irq(cap_irq), .top_pulse(top_pulse), .bottom_pulse(bottom_pulse),
        .count_down(count_down), .waveform_mode_field(waveform_mode_field));
    t16c_cpu_model cpu (.mclk(mclk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (bottom_pulse === 1'b1) saw_bot = 1'b1;
        if (top_pulse === 1'b1) saw_top = 1'b1;
        if (cyc == 6000) begin
            miscompares++;
            end_sim;
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("wrong value %s: expected %0d..%0d, seen %h", nm, lo, hi, g);
        end
    endtask
    task automatic cap_wait(output int n);
        n = 0;
        while (cap_irq !== 1'b1 && n < 16) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask
    task automatic pin(input logic p);
        @(posedge mclk);
        capture_pin <= p;
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_reset;
        cpu.rd(t16c_pkg::ADDR_CNT_HI, b);
        chk("holding", 16'h0000, {8'h00, b});
        cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
        chk("counter", 16'h0000, v);
        cpu.rd16(t16c_pkg::ADDR_CAP_LO, v);
        chk("capture", 16'h0000, v);
        cpu.rd(t16c_pkg::ADDR_FLAGS, b);
        chk("flags", 16'h0000, {8'h00, b});
        cpu.rd(4'hf, b);
        chk("unmapped", 16'h0000, {8'h00, b});
    endtask
    task automatic t_counter;
        cpu.wr16(t16c_pkg::ADDR_CNT_LO, 16'h01ff);
        repeat (5) @(posedge mclk);
        cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
        chk("stopped counter", 16'h01ff, v);
        for (int c = 1; c < 4; c++) begin
            cpu.wr16(t16c_pkg::ADDR_CNT_LO, 16'h0000);
            cpu.wr(t16c_pkg::ADDR_CTRL_B, {5'h00, 3'(c)});
            repeat (128) @(posedge mclk);
            cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
            cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
            chk_rng("ticks", (130 >> (3 * (c - 1))) - 2, (130 >> (3 * (c - 1))) + 2, v);
        end
        cpu.wr(t16c_pkg::ADDR_CNT_LO, 8'h00);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h04);
        repeat (3) begin
            @(posedge mclk);
            ext_tick <= 1'b1;
            @(posedge mclk);
            ext_tick <= 1'b0;
        end
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
        cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
        chk("external ticks", 16'h0003, v);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, {5'h00, t16c_pkg::CS_DIV1});
        cpu.wr16(t16c_pkg::ADDR_CNT_LO, 16'h4000);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
        cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
        chk("write while running", 16'h4002, v);
    endtask
    task automatic t_overflow;
        saw_bot = 1'b0;
        cpu.wr16(t16c_pkg::ADDR_CNT_LO, 16'hfffd);
        cpu.wr(t16c_pkg::ADDR_IRQ_EN, 8'h01);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, {5'h00, t16c_pkg::CS_DIV1});
        repeat (10) @(posedge mclk);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h00);
        #1;
        chk("overflow request", 16'h0001, {15'h0000, ovf_irq});
        chk("bottom seen", 16'h0001, {15'h0000, saw_bot});
        @(posedge mclk);
        ovf_irq_ack <= 1'b1;
        @(posedge mclk);
        ovf_irq_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("overflow serviced", 16'h0000, {15'h0000, ovf_irq});
    endtask
    task automatic t_capture;
        cpu.wr16(t16c_pkg::ADDR_CNT_LO, 16'h0abc);
        cpu.wr(t16c_pkg::ADDR_IRQ_EN, 8'h02);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h40);
        pin(1'b1);
        cap_wait(l0);
        chk("capture request", 16'h0001, {15'h0000, cap_irq});
        cpu.rd16(t16c_pkg::ADDR_CAP_LO, v);
        chk("captured value", 16'h0abc, v);
        @(posedge mclk);
        cap_irq_ack <= 1'b1;
        @(posedge mclk);
        cap_irq_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("capture serviced", 16'h0000, {15'h0000, cap_irq});
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'hc0);
        pin(1'b0);
        repeat (12) @(posedge mclk);
        #1;
        chk("falling ignored", 16'h0000, {15'h0000, cap_irq});
        pin(1'b1);
        cap_wait(l1);
        chk("filter delay", 16'(l0 + 4), 16'(l1));
        cpu.clr_cap();
        pin(1'b0);
        repeat (10) @(posedge mclk);
        cpu.clr_cap();
        pin(1'b1);
        repeat (3) @(posedge mclk);
        capture_pin <= 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        chk("glitch filtered", 16'h0000, {15'h0000, cap_irq});
    endtask
    task automatic t_comparator;
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h40);
        cpu.wr(t16c_pkg::ADDR_CMP_CTRL, 8'h04);
        repeat (4) @(posedge mclk);
        cpu.clr_cap();
        pin(1'b1);
        repeat (8) @(posedge mclk);
        #1;
        chk("pin deselected", 16'h0000, {15'h0000, cap_irq});
        @(posedge mclk);
        comparator_output <= 1'b1;
        cap_wait(l0);
        chk("comparator capture", 16'h0001, {15'h0000, cap_irq});
        cpu.wr(t16c_pkg::ADDR_CMP_CTRL, 8'h00);
        repeat (4) @(posedge mclk);
        cpu.clr_cap();
    endtask
    task automatic t_top_mode;
        cpu.wr16(t16c_pkg::ADDR_CAP_LO, 16'h1234);
        cpu.rd16(t16c_pkg::ADDR_CAP_LO, v);
        chk("capture write refused", 16'h0abc, v);
        cpu.wr(t16c_pkg::ADDR_CTRL_A, 8'h02);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h58);
        cpu.wr(t16c_pkg::ADDR_CNT_HI, 8'h05);
        cpu.wr(t16c_pkg::ADDR_CNT_LO, 8'h11);
        cpu.wr(t16c_pkg::ADDR_CAP_LO, 8'h22);
        cpu.rd16(t16c_pkg::ADDR_CNT_LO, v);
        chk("shared high counter", 16'h0511, v);
        cpu.rd16(t16c_pkg::ADDR_CAP_LO, v);
        chk("top capture written", 16'h0522, v);
        pin(1'b0);
        repeat (4) @(posedge mclk);
        pin(1'b1);
        repeat (12) @(posedge mclk);
        #1;
        chk("edge path off", 16'h0000, {15'h0000, cap_irq});
    endtask
    task automatic t_dual;
        saw_top = 1'b0;
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h10);
        cpu.wr16(t16c_pkg::ADDR_CAP_LO, 16'h0004);
        cpu.wr(t16c_pkg::ADDR_CNT_LO, 8'h00);
        cpu.wr(t16c_pkg::ADDR_IRQ_EN, 8'h01);
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h11);
        repeat (7) @(posedge mclk);
        #1;
        chk("mode field", 16'h000a, {12'h000, waveform_mode_field});
        chk("down slope", 16'h0001, {15'h0000, count_down});
        cpu.wr(t16c_pkg::ADDR_CTRL_B, 8'h10);
        #1;
        chk("bottom overflow", 16'h0001, {15'h0000, ovf_irq});
        chk("top seen", 16'h0001, {15'h0000, saw_top});
    endtask
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        capture_pin = 1'b0;
        comparator_output = 1'b0;
        ext_tick = 1'b0;
        ovf_irq_ack = 1'b0;
        cap_irq_ack = 1'b0;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_counter();
        t_overflow();
        t_capture();
        t_comparator();
        t_top_mode();
        t_dual();
        end_sim;
    end
endmodule
bind t16c_timer t16c_checker chk_i (.mclk(mclk), .nrst(nrst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cap_irq_ack(cap_irq_ack), .ovf_irq(ovf_irq), .cap_irq(cap_irq),
    .top_pulse(top_pulse), .bottom_pulse(bottom_pulse), .count_down(count_down),
    .waveform_mode_field(waveform_mode_field));
